//--- logic/dbm_defines.vh
`ifndef DBM_DEFINES_VH
`define DBM_DEFINES_VH
// descriptor field indices, counted in descriptor fields
`define DBM_TXD_STATUS    3'h0
`define DBM_TXD_PKT_SIZE  3'h1
`define DBM_TXD_FRAG_CNT  3'h2
`define DBM_TXD_FIRST_IDX 3'h3
`define DBM_RXD_STATUS    3'h0
`define DBM_RXD_BYTECNT   3'h1
`define DBM_RXD_PTR0      3'h2
`define DBM_RXD_PTR1      3'h3
`define DBM_RXD_LINK      3'h4
`define DBM_RSRC_FIELDS   3'h4
// field spacing in bytes
`define DBM_FIELD_STEP16  16'h0002
`define DBM_FIELD_STEP32  16'h0004
// buffer data word size in bytes
`define DBM_DATA_STEP     32'h00000002
// link bit marking the end of the list
`define DBM_LINK_EOL_BIT  0
`endif

//--- logic/dbm_core.v
// Contract
// R1: one packet per transmit descriptor and buffer
// R2: gather transmit packet from scattered fragments
// R3: read size, location, fragments; write status back
// R4: follow transmit links after one command
// R5: software loads first descriptor, then commands
// R6: software prepares receive lists before reception
// R7: bind receive descriptor only after packet stored
// R8: many packets per buffer, one descriptor each
// R9: packet stored contiguously in one buffer
// R10: receive descriptor points to, describes packet
// R11: resource area is a circular queue
// R12: fetch fresh buffer when room runs short
// R13: address is upper base plus offset
// R14: each base pairs with its offset registers
// R15: all three bases may be equal
// R16: suffix 0 low half, 1 high half
// R17: read pointer advances four fields, wraps
// R18: new resource only when count below threshold
`timescale 1ns/1ps
`default_nettype none
`include "dbm_defines.vh"
module dbm_core (
	input  wire        clock,
	input  wire        rst_n,
	input  wire        mode32,
	input  wire        rx_enable,
	input  wire [15:0] tx_descriptor_base_upper,
	input  wire [15:0] rx_descriptor_base_upper,
	input  wire [15:0] rx_resource_base_upper,
	input  wire [15:0] resource_area_start,
	input  wire [15:0] resource_area_end,
	input  wire [15:0] resource_write_pointer,
	input  wire [15:0] end_of_buffer_threshold,
	input  wire        rrp_load,
	input  wire [15:0] rrp_value,
	input  wire        current_rx_descriptor_offset_load,
	input  wire [15:0] current_rx_descriptor_offset_value,
	input  wire        current_tx_descriptor_offset_load,
	input  wire [15:0] current_tx_descriptor_offset_value,
	input  wire        tx_command,
	output wire        mem_req,
	output wire        mem_we,
	output wire [31:0] mem_addr,
	output wire [15:0] mem_wdata,
	input  wire [15:0] mem_rdata,
	input  wire        mem_ack,
	output wire        tx_valid,
	output wire [15:0] tx_data,
	output wire        tx_last,
	output wire [15:0] tx_packet_size,
	input  wire        tx_ready,
	input  wire        tx_stat_valid,
	input  wire [15:0] tx_stat,
	input  wire        rx_valid,
	input  wire [15:0] rx_data,
	input  wire        rx_last,
	input  wire [15:0] rx_stat,
	output wire        rx_ready,
	output wire        rx_overflow,
	output wire        resource_empty,
	output wire        tx_busy,
	output wire        rx_buffer_valid,
	output wire [15:0] resource_read_pointer,
	output wire [15:0] current_rx_descriptor_offset,
	output wire [15:0] current_tx_descriptor_offset,
	output wire [31:0] current_rx_buffer_address,
	output wire [31:0] remaining_buffer_word_count
);
	localparam [3:0] S_IDLE = 4'h0;
	localparam [3:0] S_TXD  = 4'h1;
	localparam [3:0] S_TXF  = 4'h2;
	localparam [3:0] S_TXG  = 4'h3;
	localparam [3:0] S_TXO  = 4'h4;
	localparam [3:0] S_TXS  = 4'h5;
	localparam [3:0] S_TXL  = 4'h6;
	localparam [3:0] S_RXR  = 4'h7;
	localparam [3:0] S_RXW  = 4'h8;
	localparam [3:0] S_RXD  = 4'h9;
	localparam [3:0] S_RXL  = 4'hA;

	reg [3:0]  state_ff;
	reg [2:0]  idx_ff;
	reg        req_ff;
	reg        we_ff;
	reg [31:0] addr_ff;
	reg [15:0] wdata_ff;
	reg        tx_pend_ff;
	reg [15:0] dptr_ff;
	reg [15:0] tps_ff;
	reg [15:0] tfc_ff;
	reg [15:0] tfs_ff;
	reg [31:0] tsa_ff;
	reg [15:0] txd_ff;
	reg        txl_ff;
	reg [15:0] rrp_ff;
	reg [15:0] current_rx_descriptor_offset_ff;
	reg [15:0] current_tx_descriptor_offset_ff;
	reg [31:0] crba_ff;
	reg [31:0] rbwc_ff;
	reg [31:0] tcba_ff;
	reg [31:0] trbwc_ff;
	reg        buf_ok_ff;
	reg [31:0] pkt_start_ff;
	reg [15:0] pkt_words_ff;
	reg        last_ff;
	reg [15:0] rstat_ff;

	wire [15:0] fstep = mode32 ? `DBM_FIELD_STEP32 : `DBM_FIELD_STEP16;
	wire [15:0] rrp_next = rrp_ff + (fstep << 2);
	wire        rsrc_avail = (rrp_ff != resource_write_pointer);

	// upper base forms the high half, offset the low half; bases may be equal
	function [31:0] dbm_addr; // R15
		input [15:0] upper;
		input [15:0] offset;
		begin
			dbm_addr = {upper, offset}; // R13
		end
	endfunction

	// offset of field n from a descriptor start
	function [15:0] dbm_field;
		input [15:0] base;
		input [2:0]  n;
		input [15:0] step;
		begin
			dbm_field = base + ({13'h0000, n} * step);
		end
	endfunction

	assign mem_req   = req_ff;
	assign mem_we    = we_ff;
	assign mem_addr  = addr_ff;
	assign mem_wdata = wdata_ff;
	assign tx_valid  = (state_ff == S_TXO);
	assign tx_data   = txd_ff;
	assign tx_last   = txl_ff;
	assign tx_packet_size = tps_ff;
	assign rx_ready  = (state_ff == S_RXW) && !req_ff && (rbwc_ff != 32'h00000000);
	assign rx_overflow    = (state_ff == S_RXW) && (rbwc_ff == 32'h00000000);
	assign resource_empty = !rsrc_avail;
	assign tx_busy   = tx_pend_ff || (state_ff >= S_TXD && state_ff <= S_TXL);
	assign rx_buffer_valid = buf_ok_ff;
	assign resource_read_pointer        = rrp_ff;
	assign current_rx_descriptor_offset = current_rx_descriptor_offset_ff;
	assign current_tx_descriptor_offset = current_tx_descriptor_offset_ff;
	assign current_rx_buffer_address    = crba_ff;
	assign remaining_buffer_word_count  = rbwc_ff;

	always @(posedge clock) begin
		if (!rst_n) begin
			state_ff <= S_IDLE;
			idx_ff <= 3'h0;
			req_ff <= 1'b0;
			we_ff <= 1'b0;
			addr_ff <= 32'h00000000;
			wdata_ff <= 16'h0000;
			tx_pend_ff <= 1'b0;
			dptr_ff <= 16'h0000;
			tps_ff <= 16'h0000;
			tfc_ff <= 16'h0000;
			tfs_ff <= 16'h0000;
			tsa_ff <= 32'h00000000;
			txd_ff <= 16'h0000;
			txl_ff <= 1'b0;
			rrp_ff <= 16'h0000;
			current_rx_descriptor_offset_ff <= 16'h0000;
			current_tx_descriptor_offset_ff <= 16'h0000;
			crba_ff <= 32'h00000000;
			rbwc_ff <= 32'h00000000;
			tcba_ff <= 32'h00000000;
			trbwc_ff <= 32'h00000000;
			buf_ok_ff <= 1'b0;
			pkt_start_ff <= 32'h00000000;
			pkt_words_ff <= 16'h0000;
			last_ff <= 1'b0;
			rstat_ff <= 16'h0000;
		end else begin
			if (rrp_load)
				rrp_ff <= rrp_value;
			if (current_rx_descriptor_offset_load)
				current_rx_descriptor_offset_ff <= current_rx_descriptor_offset_value;
			if (current_tx_descriptor_offset_load)
				current_tx_descriptor_offset_ff <= current_tx_descriptor_offset_value; // R5
			if (tx_command)
				tx_pend_ff <= 1'b1;
			case (state_ff)
			S_IDLE: begin
				idx_ff <= 3'h0;
				if (rx_enable && !buf_ok_ff && rsrc_avail) begin
					state_ff <= S_RXR; // R12
				end else if (rx_enable && buf_ok_ff && rx_valid) begin
					pkt_start_ff <= crba_ff;
					pkt_words_ff <= 16'h0000;
					state_ff <= S_RXW;
				end else if (tx_pend_ff && !tx_command) begin
					tx_pend_ff <= 1'b0;
					dptr_ff <= dbm_field(current_tx_descriptor_offset_ff, `DBM_TXD_PKT_SIZE, fstep);
					state_ff <= S_TXD;
				end
			end
			S_TXD: begin
				if (!req_ff) begin
					req_ff <= 1'b1;
					we_ff <= 1'b0;
					addr_ff <= dbm_addr(tx_descriptor_base_upper, dptr_ff); // R14
				end else if (mem_ack) begin
					req_ff <= 1'b0;
					dptr_ff <= dptr_ff + fstep;
					if (idx_ff == 3'h0) begin
						tps_ff <= mem_rdata; // R3
						idx_ff <= 3'h1;
					end else begin
						tfc_ff <= mem_rdata; // R3
						idx_ff <= 3'h0;
						state_ff <= (mem_rdata == 16'h0000) ? S_TXS : S_TXF;
					end
				end
			end
			S_TXF: begin
				if (!req_ff) begin
					req_ff <= 1'b1;
					we_ff <= 1'b0;
					addr_ff <= dbm_addr(tx_descriptor_base_upper, dptr_ff);
				end else if (mem_ack) begin
					req_ff <= 1'b0;
					dptr_ff <= dptr_ff + fstep;
					idx_ff <= idx_ff + 3'h1;
					if (idx_ff == 3'h0)
						tsa_ff[15:0] <= mem_rdata; // R16
					else if (idx_ff == 3'h1)
						tsa_ff[31:16] <= mem_rdata; // R16
					else begin
						tfs_ff <= mem_rdata;
						idx_ff <= 3'h0;
						tfc_ff <= tfc_ff - 16'h0001;
						// empty fragment: skip straight on
						if (mem_rdata != 16'h0000)
							state_ff <= S_TXG;
						else if (tfc_ff == 16'h0001)
							state_ff <= S_TXS;
					end
				end
			end
			S_TXG: begin
				if (!req_ff) begin
					req_ff <= 1'b1;
					we_ff <= 1'b0;
					addr_ff <= tsa_ff; // R2
				end else if (mem_ack) begin
					req_ff <= 1'b0;
					txd_ff <= mem_rdata;
					txl_ff <= (tfs_ff == 16'h0001) && (tfc_ff == 16'h0000); // R1
					state_ff <= S_TXO;
				end
			end
			S_TXO: begin
				if (tx_ready) begin
					txl_ff <= 1'b0;
					tsa_ff <= tsa_ff + `DBM_DATA_STEP;
					tfs_ff <= tfs_ff - 16'h0001;
					if (tfs_ff != 16'h0001)
						state_ff <= S_TXG;
					else if (tfc_ff != 16'h0000)
						state_ff <= S_TXF; // R2
					else
						state_ff <= S_TXS;
				end
			end
			S_TXS: begin
				if (!req_ff && tx_stat_valid) begin
					req_ff <= 1'b1;
					we_ff <= 1'b1;
					wdata_ff <= tx_stat;
					addr_ff <= dbm_addr(tx_descriptor_base_upper,
						dbm_field(current_tx_descriptor_offset_ff, `DBM_TXD_STATUS, fstep)); // R3
				end else if (req_ff && mem_ack) begin
					req_ff <= 1'b0;
					we_ff <= 1'b0;
					state_ff <= S_TXL;
				end
			end
			S_TXL: begin
				if (!req_ff) begin
					req_ff <= 1'b1;
					addr_ff <= dbm_addr(tx_descriptor_base_upper, dptr_ff);
				end else if (mem_ack) begin
					req_ff <= 1'b0;
					if (!mem_rdata[`DBM_LINK_EOL_BIT]) begin
						current_tx_descriptor_offset_ff <= mem_rdata; // R4
						tx_pend_ff <= 1'b1; // R4
					end
					state_ff <= S_IDLE;
				end
			end
			S_RXR: begin
				if (!req_ff) begin
					req_ff <= 1'b1;
					we_ff <= 1'b0;
					addr_ff <= dbm_addr(rx_resource_base_upper, dbm_field(rrp_ff, idx_ff, fstep)); // R14
				end else if (mem_ack) begin
					req_ff <= 1'b0;
					idx_ff <= idx_ff + 3'h1;
					case (idx_ff)
					3'h0: tcba_ff[15:0] <= mem_rdata; // R16
					3'h1: tcba_ff[31:16] <= mem_rdata;
					3'h2: trbwc_ff[15:0] <= mem_rdata;
					default: trbwc_ff[31:16] <= mem_rdata;
					endcase
					if (idx_ff == `DBM_RSRC_FIELDS - 3'h1) begin
						crba_ff <= tcba_ff;
						rbwc_ff <= {mem_rdata, trbwc_ff[15:0]};
						buf_ok_ff <= 1'b1;
						// wrap at the end of the circular area
						rrp_ff <= (rrp_next == resource_area_end) ? resource_area_start : rrp_next; // R11 R17
						state_ff <= S_IDLE;
					end
				end
			end
			S_RXW: begin
				if (rx_valid && rx_ready) begin
					req_ff <= 1'b1;
					we_ff <= 1'b1;
					wdata_ff <= rx_data;
					addr_ff <= crba_ff; // R9
					last_ff <= rx_last;
					if (rx_last)
						rstat_ff <= rx_stat;
				end else if (req_ff && mem_ack) begin
					req_ff <= 1'b0;
					we_ff <= 1'b0;
					crba_ff <= crba_ff + `DBM_DATA_STEP; // R9
					rbwc_ff <= rbwc_ff - 32'h00000001;
					pkt_words_ff <= pkt_words_ff + 16'h0001;
					if (last_ff) begin
						idx_ff <= 3'h0;
						state_ff <= S_RXD; // R7
					end
				end
			end
			S_RXD: begin
				if (!req_ff) begin
					req_ff <= 1'b1;
					we_ff <= 1'b1;
					addr_ff <= dbm_addr(rx_descriptor_base_upper, dbm_field(current_rx_descriptor_offset_ff, idx_ff, fstep)); // R14
					case (idx_ff)
					`DBM_RXD_STATUS:  wdata_ff <= rstat_ff;
					`DBM_RXD_BYTECNT: wdata_ff <= {pkt_words_ff[14:0], 1'b0};
					`DBM_RXD_PTR0:    wdata_ff <= pkt_start_ff[15:0]; // R10
					default:          wdata_ff <= pkt_start_ff[31:16]; // R10
					endcase
				end else if (mem_ack) begin
					req_ff <= 1'b0;
					we_ff <= 1'b0;
					idx_ff <= idx_ff + 3'h1;
					if (idx_ff == `DBM_RXD_PTR1)
						state_ff <= S_RXL;
				end
			end
			S_RXL: begin
				if (!req_ff) begin
					req_ff <= 1'b1;
					addr_ff <= dbm_addr(rx_descriptor_base_upper, dbm_field(current_rx_descriptor_offset_ff, `DBM_RXD_LINK, fstep));
				end else if (mem_ack) begin
					req_ff <= 1'b0;
					current_rx_descriptor_offset_ff <= mem_rdata; // R8
					if (rbwc_ff < {16'h0000, end_of_buffer_threshold})
						buf_ok_ff <= 1'b0; // R18 R12
					state_ff <= S_IDLE;
				end
			end
			default: state_ff <= S_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

//--- testbench/dbm_core_chk.sv
`timescale 1ns/1ps
`default_nettype none
module dbm_core_chk (
	input wire logic        clock,
	input wire logic        rst_n,
	input wire logic        mode32,
	input wire logic        rrp_load,
	input wire logic        mem_req,
	input wire logic        mem_ack,
	input wire logic [31:0] mem_addr,
	input wire logic [15:0] mem_wdata,
	input wire logic        tx_valid,
	input wire logic        tx_ready,
	input wire logic        tx_last,
	input wire logic [15:0] tx_data,
	input wire logic        rx_valid,
	input wire logic        rx_ready,
	input wire logic        rx_last,
	input wire logic        rx_overflow,
	input wire logic        rx_buffer_valid,
	input wire logic        resource_empty,
	input wire logic [15:0] resource_area_start,
	input wire logic [15:0] resource_write_pointer,
	input wire logic [15:0] resource_read_pointer,
	input wire logic [31:0] remaining_buffer_word_count
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	logic [31:0] wc_exp_ff;
	always @(posedge clock) begin
		if (rx_valid && rx_ready) begin
			wc_exp_ff <= remaining_buffer_word_count - 32'h1;
		end
	end
	req_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_wdata))
		else $error("request changed before ack");
	req_gap_a: assert property (mem_req && mem_ack |=> !mem_req)
		else $error("request held after ack");
	empty_flag_a: assert property (resource_empty == (resource_read_pointer == resource_write_pointer))
		else $error("empty flag wrong");
	rrp_step_a: assert property (!rrp_load ##1 resource_read_pointer != $past(resource_read_pointer) |->
		resource_read_pointer == $past(resource_read_pointer) + (mode32 ? 16'h0010 : 16'h0008)
		|| resource_read_pointer == resource_area_start) else $error("read pointer step wrong");
	rx_refuse_a: assert property (!rx_buffer_valid || remaining_buffer_word_count == 32'h0 |-> !rx_ready)
		else $error("receive taken without room");
	overflow_a: assert property (rx_overflow |-> !rx_ready && remaining_buffer_word_count == 32'h0)
		else $error("overflow flag wrong");
	rbwc_dec_a: assert property (rx_valid && rx_ready |=> ##[0:20] remaining_buffer_word_count == wc_exp_ff)
		else $error("word count not decremented");
	tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
		else $error("transmit word changed before taken");
	cover property (tx_valid && tx_ready && tx_last);
	cover property (rx_valid && rx_ready && rx_last);
	cover property ($rose(resource_empty));
endmodule
bind dbm_core dbm_core_chk i_chk (.*);
`default_nettype wire

//--- testbench/dbm_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module dbm_mem_model (
	input  wire logic        clock,
	input  wire logic        mem_req,
	input  wire logic        mem_we,
	input  wire logic [31:0] mem_addr,
	input  wire logic [15:0] mem_wdata,
	output var  logic [15:0] mem_rdata,
	output var  logic        mem_ack
);
	logic [15:0] mem [0:2047];
	logic [1:0]  wait_ff = 2'h0;
	logic        slow_ff = 1'b0;
	wire  [10:0] idx = {mem_addr[17:16], mem_addr[9:1]};
	// prompt and slow answers alternate; data toggles while not answering
	always @(posedge clock) begin
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if (mem_req && !mem_ack) begin
			if (wait_ff != 2'h0) begin
				wait_ff <= wait_ff - 2'h1;
			end else begin
				mem_ack <= 1'b1;
				mem_rdata <= mem[idx];
				slow_ff <= ~slow_ff;
				wait_ff <= slow_ff ? 2'h0 : 2'h2;
				if (mem_we) begin
					mem[idx] <= mem_wdata;
				end
			end
		end
	end
endmodule
`default_nettype wire

//--- testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        clock, rst_n, mode32, rx_enable, rrp_load, current_rx_descriptor_offset_load, current_tx_descriptor_offset_load, tx_command;
	logic        mem_req, mem_we, mem_ack, tx_valid, tx_last, tx_ready, tx_stat_valid;
	logic        rx_valid, rx_last, rx_ready, rx_overflow, resource_empty, tx_busy, rx_buffer_valid;
	logic [15:0] tx_descriptor_base_upper, rx_descriptor_base_upper, rx_resource_base_upper;
	logic [15:0] resource_area_start, resource_area_end, resource_write_pointer, end_of_buffer_threshold;
	logic [15:0] rrp_value, current_rx_descriptor_offset_value, current_tx_descriptor_offset_value, mem_wdata, mem_rdata, tx_data, tx_packet_size;
	logic [15:0] tx_stat, rx_data, rx_stat, resource_read_pointer, current_rx_descriptor_offset;
	logic [15:0] current_tx_descriptor_offset;
	logic [31:0] mem_addr, current_rx_buffer_address, remaining_buffer_word_count, d;
	int          fails, total_checks, i, k;
	logic [16:0] txq [$];
	logic [16:0] tx_exp [4] = '{17'h0B001, 17'h0B002, 17'h1B003, 17'h1B004};
	int          rw_n [3] = '{1, 2, 3};
	logic [31:0] rw_ptr [3] = '{32'h00000100, 32'h00000102, 32'h00000200};
	logic [31:0] rw_wc [3] = '{32'h5, 32'h14, 32'h11};
	logic [15:0] rw_rrp [3] = '{16'h0018, 16'h0020, 16'h0020};
	logic [15:0] rs [8] = '{16'h0100, 16'h0, 16'h0006, 16'h0, 16'h0200, 16'h0, 16'h0014, 16'h0};
	logic [15:0] td [17] = '{16'h0, 16'h0006, 16'h0002, 16'h0300, 16'h0, 16'h0001, 16'h0310, 16'h0, 16'h0002,
		16'h0014, 16'h0, 16'h0002, 16'h0001, 16'h0320, 16'h0, 16'h0001, 16'h0001};
	dbm_core i_dut (.*);
	dbm_mem_model i_mem (.*);
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	always @(posedge clock) begin
		tx_ready <= #1 ~tx_ready;
		if (tx_valid && tx_ready) txq.push_back({tx_last, tx_data});
	end
	task step;
		@(posedge clock);
		#1;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	function automatic logic [10:0] ix(input logic [31:0] a);
		return {a[17:16], a[9:1]};
	endfunction
	task put(input logic [31:0] a, input logic [15:0] v);
		i_mem.mem[ix(a)] = v;
	endtask
	task final_report;
		$display("checks %0d fails %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task hang;
		fails++;
		$display("[FAIL] %0t wait ran out", $time);
		final_report;
	endtask
	task quiet;
		int q, n;
		q = 0;
		for (n = 0; n < 600 && q < 8; n++) begin
			step;
			q = mem_req ? 0 : q + 1;
		end
		if (q < 8) hang;
	endtask
	task rx_pkt(input int n, input logic [15:0] b);
		int j, t;
		for (j = 0; j < n; j++) begin
			rx_valid = 1'b1;
			rx_data = b + 16'(j);
			rx_last = (j == n - 1);
			#1;
			for (t = 0; t < 100 && !rx_ready; t++) step;
			if (t == 100) hang;
			step;
		end
		rx_valid = 1'b0;
		rx_last = 1'b0;
	endtask
	initial begin
		{rst_n, mode32, rx_enable, rrp_load, current_rx_descriptor_offset_load, current_tx_descriptor_offset_load, tx_command, tx_ready} = '0;
		{tx_stat_valid, rx_valid, rx_last, rrp_value, current_rx_descriptor_offset_value, current_tx_descriptor_offset_value, rx_data, rx_stat} = '0;
		fails = 0;
		total_checks = 0;
		{tx_descriptor_base_upper, rx_descriptor_base_upper, rx_resource_base_upper} = {16'h1, 16'h2, 16'h3};
		{resource_area_start, resource_area_end, resource_write_pointer} = {16'h10, 16'h28, 16'h20};
		end_of_buffer_threshold = 16'h0005;
		tx_stat = 16'h5A01;
		for (i = 0; i < 8; i++) put(32'h00030010 + 32'(2 * i), rs[i]);
		for (i = 0; i < 3; i++) put(32'h00020008 + 32'(i * 16), 16'(16 + i * 16));
		for (i = 0; i < 17; i++) put(32'h00010000 + 32'(2 * i), td[i]);
		put(32'h300, 16'hB001);
		put(32'h310, 16'hB002);
		put(32'h312, 16'hB003);
		put(32'h320, 16'hB004);
		repeat (16) step;
		rst_n = 1'b1;
		chk(mem_req, 1'b0);
		chk(rx_ready, 1'b0);
		chk(tx_busy, 1'b0);
		chk(resource_read_pointer, 16'h0);
		$display("reset test done");
		{rrp_load, rrp_value, current_rx_descriptor_offset_load} = {1'b1, 16'h0010, 1'b1};
		step;
		{rrp_load, current_rx_descriptor_offset_load, rx_enable, tx_stat_valid} = 4'h3;
		quiet;
		chk(current_rx_buffer_address, 32'h100);
		chk(remaining_buffer_word_count, 32'h6);
		chk(resource_read_pointer, 16'h0018);
		for (i = 0; i < 3; i++) begin
			rx_stat = 16'h0C00 + 16'(i);
			rx_pkt(rw_n[i], 16'hA000 + 16'(i * 16));
			quiet;
			for (k = 0; k < rw_n[i]; k++) chk(i_mem.mem[ix(rw_ptr[i] + 32'(2 * k))], 16'hA000 + 16'(i * 16 + k));
			d = 32'h00020000 + 32'(i * 16);
			chk(i_mem.mem[ix(d)], rx_stat);
			chk(i_mem.mem[ix(d + 2)], 16'(2 * rw_n[i]));
			chk(i_mem.mem[ix(d + 4)], rw_ptr[i][15:0]);
			chk(i_mem.mem[ix(d + 6)], rw_ptr[i][31:16]);
			chk(current_rx_descriptor_offset, 16'(16 + i * 16));
			chk(remaining_buffer_word_count, rw_wc[i]);
			chk(resource_read_pointer, rw_rrp[i]);
			$display("rx row %0d done", i);
		end
		chk(resource_empty, 1'b1);
		chk(rx_buffer_valid, 1'b1);
		chk(rx_overflow, 1'b0);
		current_tx_descriptor_offset_load = 1'b1;
		step;
		{current_tx_descriptor_offset_load, tx_command} = 2'h1;
		step;
		tx_command = 1'b0;
		chk(tx_busy, 1'b1);
		quiet;
		chk(txq.size(), 32'h4);
		for (k = 0; k < 4; k++) chk(txq[k], tx_exp[k]);
		chk(i_mem.mem[ix(32'h00010000)], 16'h5A01);
		chk(i_mem.mem[ix(32'h00010014)], 16'h5A01);
		chk(tx_packet_size, 16'h0002);
		chk(current_tx_descriptor_offset, 16'h0014);
		chk(tx_busy, 1'b0);
		$display("tx test done");
		final_report;
	end
endmodule
`default_nettype wire
